// *** src/hssp_pkg.sv ***
package hssp_pkg;
  // ==========================================
  // Host kind strap decode
  typedef enum logic [1:0] {
    HSSP_HOST_UART,
    HSSP_HOST_SPI,
    HSSP_HOST_I2C,
    HSSP_HOST_I2CL
  } hssp_host_kind_t;

  // ==========================================
  // Command byte layout
  localparam int HSSP_DIR_BIT = 0;
  localparam int HSSP_ADDR_LSB = 1;
  localparam int HSSP_ADDR_W = 7;
  localparam int HSSP_DATA_W = 8;
  localparam logic [6:0] HSSP_FIFO_ADDR = 7'h05;
  localparam logic [6:0] HSSP_ADDR_RST = 7'h00;
  localparam logic [7:0] HSSP_MISO_IDLE = 8'h00;

  // ==========================================
  // Timing
  localparam int HSSP_CLK_MHZ = 125;
  localparam int HSSP_SPI_MAX_MBPS = 10;
  localparam int HSSP_CYC_PER_BIT = HSSP_CLK_MHZ / HSSP_SPI_MAX_MBPS;
  localparam int HSSP_COLD_RESET_CYC = 16;
endpackage

// *** src/hssp_sync.sv ***
`timescale 1ns/1ns
`default_nettype none
module hssp_sync #(
  parameter int W = 4
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  // ==========================================
  // Two flop synchroniser per bit
  logic [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_q[i] <= 1'b0;
          q[i] <= 1'b0;
        end else begin
          meta_q[i] <= d[i];
          q[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// *** src/hssp_strap.sv ***
`timescale 1ns/1ns
`default_nettype none
module hssp_strap
  import hssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic host_kind_strap_lo,
  input wire logic host_kind_strap_hi,
  output hssp_host_kind_t host_kind_q,
  output logic host_kind_valid_q
);
  // ==========================================
  // Cold reset wait, then one strap capture
  logic [4:0] cnt_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      cnt_q <= 5'h00;
    end else if (!host_kind_valid_q) begin
      cnt_q <= cnt_q + 5'h01;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      host_kind_q <= HSSP_HOST_UART;
      host_kind_valid_q <= 1'b0;
    end else if (!host_kind_valid_q && cnt_q == 5'(HSSP_COLD_RESET_CYC)) begin
      // RL1: sample after cold reset
      host_kind_valid_q <= 1'b1;
      // RL2: strap decode
      case ({host_kind_strap_hi, host_kind_strap_lo})
        2'b00: host_kind_q <= HSSP_HOST_UART;
        2'b10: host_kind_q <= HSSP_HOST_SPI;
        2'b01: host_kind_q <= HSSP_HOST_I2C;
        default: host_kind_q <= HSSP_HOST_I2CL;
      endcase
    end
  end
endmodule
`default_nettype wire

// *** src/hssp_top.sv ***
// Functional notes
// RL1: After power-up or power-down exit the port resets and samples the straps once the cold reset wait ends.
// RL2: Straps 00 give UART, hi=1 lo=0 give SPI, lo=1 hi=0 give I2C, both high give I2C-L; SPI uses pins a..d.
// RL3: The host is the master and makes every serial clock edge and drives command and write data.
// RL4: The port is only a slave and returns read data on the MISO pin.
// RL5: The port works at serial rates up to 10 Mbit/s.
// RL6: While select is high the port is disabled and its bit count, mode and address are held in reset.
// RL7: The host raises select between commands so each starts fresh.
// RL8: Every byte on both data lines goes most significant bit first.
// RL9: The host changes MOSI after a falling edge and the port samples it on the rising edge.
// RL10: The port changes MISO on the falling edge of the serial clock.
// RL11: The serial clock idles low.
// RL12: The first byte holds direction in bit 0 (1 read) and the address in bits 7..1.
// RL13: In a read each address byte returns the data of the one before, ending with a 00h byte.
// RL14: In a write the data bytes go to the given address and then to each next one.
// RL15: Writes to the FIFO address do not advance it, so all bytes go to the FIFO.
// RL16: The host keeps select low through a multi-byte transfer.
// RL17: MISO carries zero whenever its value has no meaning.
`timescale 1ns/1ns
`default_nettype none
module hssp_top
  import hssp_pkg::*;
#(
  parameter int CYC_PER_BIT = HSSP_CYC_PER_BIT,
  parameter logic [HSSP_ADDR_W-1:0] FIFO_ADDR = HSSP_FIFO_ADDR
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_kind_strap_lo,
  input wire logic host_kind_strap_hi,
  input wire logic host_pin_a,
  input wire logic host_pin_b,
  input wire logic host_pin_d,
  output logic host_pin_c_q,
  output logic host_pin_c_oe_n_q,
  output hssp_host_kind_t host_kind_q,
  output logic host_kind_valid_q,
  output logic reg_wr_q,
  output logic reg_rd_q,
  output logic fifo_push_q,
  output logic [HSSP_ADDR_W-1:0] reg_addr_q,
  output logic [HSSP_DATA_W-1:0] reg_wdata_q,
  input wire logic [HSSP_DATA_W-1:0] reg_rdata
);
  // ==========================================
  // Pin synchronisation
  // RL5: samples per bit
  // Half a bit must outlast the two sync flops, the edge detect and the MISO register
  if (CYC_PER_BIT < 8) begin : g_rate_chk
    $error("Clock too slow for the serial rate");
  end

  logic [2:0] pins_s;
  logic mosi_s;
  logic sck_s;
  logic nss_s;
  hssp_sync #(.W(3)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({host_pin_d, host_pin_b, host_pin_a}),
    .q(pins_s)
  );
  assign mosi_s = pins_s[0];
  assign sck_s = pins_s[1];
  assign nss_s = pins_s[2];

  // Straps are pins as well, so they pass the same two flops before the capture
  logic [1:0] straps_s;
  hssp_sync #(.W(2)) u_strap_sync (
    .clk(clk),
    .rst(rst),
    .d({host_kind_strap_hi, host_kind_strap_lo}),
    .q(straps_s)
  );

  hssp_strap u_strap (
    .clk(clk),
    .rst(rst),
    .host_kind_strap_lo(straps_s[0]),
    .host_kind_strap_hi(straps_s[1]),
    .host_kind_q(host_kind_q),
    .host_kind_valid_q(host_kind_valid_q)
  );

  logic spi_en;
  assign spi_en = host_kind_valid_q && (host_kind_q == HSSP_HOST_SPI);

  // ==========================================
  // Edge detect on the synchronised clock
  logic sck_prev_q;
  logic sck_rise;
  logic sck_fall;
  logic active;
  always_ff @(posedge clk) begin
    if (rst) begin
      sck_prev_q <= 1'b0;
    end else begin
      sck_prev_q <= sck_s;
    end
  end
  // RL11: idle low, so first edge is rising
  assign sck_rise = sck_s && !sck_prev_q;
  assign sck_fall = !sck_s && sck_prev_q;
  // RL6: select high disables port
  assign active = spi_en && !nss_s;

  // ==========================================
  // Receive shifter
  typedef enum logic [1:0] {
    HSSP_ST_CMD,
    HSSP_ST_READ,
    HSSP_ST_WRITE
  } hssp_state_t;

  hssp_state_t state_q;
  logic [2:0] bit_cnt_q;
  logic [HSSP_DATA_W-1:0] rx_sh_q;
  logic [HSSP_DATA_W-1:0] rx_byte;
  logic byte_done;
  logic [HSSP_ADDR_W-1:0] addr_q;

  // RL8: MSB first shift in
  assign rx_byte = {rx_sh_q[HSSP_DATA_W-2:0], mosi_s};
  assign byte_done = active && sck_rise && (bit_cnt_q == 3'h7);

  always_ff @(posedge clk) begin
    if (rst || !active) begin
      // RL6: bit count held in reset
      bit_cnt_q <= 3'h0;
      rx_sh_q <= 8'h00;
    end else if (sck_rise) begin
      // RL9: sample on rising edge
      bit_cnt_q <= bit_cnt_q + 3'h1;
      rx_sh_q <= rx_byte;
    end
  end

  // ==========================================
  // Command decode and address tracking
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      // RL6: mode and address held in reset
      state_q <= HSSP_ST_CMD;
      addr_q <= HSSP_ADDR_RST;
    end else if (byte_done) begin
      case (state_q)
        HSSP_ST_CMD: begin
          // RL12: direction in bit 0
          addr_q <= rx_byte[HSSP_DATA_W-1:HSSP_ADDR_LSB];
          state_q <= rx_byte[HSSP_DIR_BIT] ? HSSP_ST_READ : HSSP_ST_WRITE;
        end
        HSSP_ST_READ: begin
          // RL13: each byte is the next address
          addr_q <= rx_byte[HSSP_DATA_W-1:HSSP_ADDR_LSB];
        end
        HSSP_ST_WRITE: begin
          // RL14: auto increment
          // RL15: FIFO address holds
          if (addr_q != FIFO_ADDR) begin
            addr_q <= addr_q + 7'h01;
          end
        end
        default: begin
          state_q <= HSSP_ST_CMD;
        end
      endcase
    end
  end

  // ==========================================
  // Register side strobes
  logic rd_pend_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      fifo_push_q <= 1'b0;
      reg_addr_q <= HSSP_ADDR_RST;
      reg_wdata_q <= 8'h00;
    end else begin
      reg_wr_q <= 1'b0;
      reg_rd_q <= 1'b0;
      fifo_push_q <= 1'b0;
      if (byte_done && state_q == HSSP_ST_WRITE) begin
        // RL14: store data byte at current address
        reg_addr_q <= addr_q;
        reg_wdata_q <= rx_byte;
        // RL15: FIFO writes push
        if (addr_q == FIFO_ADDR) begin
          fifo_push_q <= 1'b1;
        end else begin
          reg_wr_q <= 1'b1;
        end
      end else if (byte_done && state_q != HSSP_ST_WRITE && rx_byte[HSSP_DIR_BIT] | (state_q == HSSP_ST_READ)) begin
        // RL13: fetch data of the address just sent
        reg_addr_q <= rx_byte[HSSP_DATA_W-1:HSSP_ADDR_LSB];
        reg_rd_q <= 1'b1;
      end
    end
  end

  // ==========================================
  // Transmit shifter
  // Read data is latched two cycles after the strobe; a whole high half
  // period remains before the first falling edge, so no stall is needed.
  logic [HSSP_DATA_W-1:0] tx_sh_q;
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      rd_pend_q <= 1'b0;
    end else begin
      rd_pend_q <= reg_rd_q;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || !active) begin
      // RL17: zero when meaningless
      tx_sh_q <= HSSP_MISO_IDLE;
    end else if (rd_pend_q) begin
      tx_sh_q <= reg_rdata;
    end else if (sck_fall && bit_cnt_q != 3'h0) begin
      // RL8: MSB first shift out
      tx_sh_q <= {tx_sh_q[HSSP_DATA_W-2:0], 1'b0};
    end else if (byte_done && state_q == HSSP_ST_WRITE) begin
      // RL17: writes return zero
      tx_sh_q <= HSSP_MISO_IDLE;
    end
  end

  // ==========================================
  // MISO pin
  always_ff @(posedge clk) begin
    if (rst || !active) begin
      host_pin_c_q <= 1'b0;
      host_pin_c_oe_n_q <= 1'b1;
    end else begin
      // RL4: slave drives MISO while selected
      host_pin_c_oe_n_q <= 1'b0;
      if (sck_fall) begin
        // RL10: update on falling edge
        host_pin_c_q <= (bit_cnt_q == 3'h0) ? tx_sh_q[HSSP_DATA_W-1] : tx_sh_q[HSSP_DATA_W-2];
      end
    end
  end
endmodule
`default_nettype wire

// *** tb/hssp_top_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module hssp_top_chk
  import hssp_pkg::*;
(
  input wire logic clk,
  input wire logic rst,
  input wire logic host_pin_b,
  input wire logic host_pin_d,
  input wire logic host_pin_c_q,
  input wire logic host_pin_c_oe_n_q,
  input wire hssp_host_kind_t host_kind_q,
  input wire logic host_kind_valid_q,
  input wire logic reg_wr_q,
  input wire logic reg_rd_q,
  input wire logic fifo_push_q,
  input wire logic [HSSP_ADDR_W-1:0] reg_addr_q
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ====
  // Strap and select
  valid_hold_a: assert property (host_kind_valid_q |=> host_kind_valid_q && $stable(host_kind_q))
    else $error("host kind moved after capture");
  oe_off_a: assert property (host_kind_q != HSSP_HOST_SPI |-> host_pin_c_oe_n_q)
    else $error("miso driven outside spi mode");
  nss_off_a: assert property (host_pin_d [*4] |-> host_pin_c_oe_n_q)
    else $error("miso driven while deselected");
  oe_on_a: assert property ((host_kind_valid_q && host_kind_q == HSSP_HOST_SPI && !host_pin_d) [*4]
    |-> !host_pin_c_oe_n_q)
    else $error("miso not driven while selected");
  // ====
  // Strobes and data line
  one_hot_a: assert property ($onehot0({reg_wr_q, reg_rd_q, fifo_push_q}))
    else $error("two strobes at once");
  push_addr_a: assert property (fifo_push_q |-> reg_addr_q == HSSP_FIFO_ADDR)
    else $error("push away from fifo address");
  strobe_sel_a: assert property (reg_wr_q || reg_rd_q || fifo_push_q |-> !$past(host_pin_d, 4))
    else $error("strobe without select");
  rd_pulse_a: assert property (reg_rd_q |=> !reg_rd_q)
    else $error("read strobe too long");
  // Sync delay is three cycles, so six high cycles leave no fall pending
  miso_hold_a: assert property (host_pin_b [*6] |-> $stable(host_pin_c_q))
    else $error("miso moved while clock high");
endmodule
bind hssp_top hssp_top_chk i_chk (.clk, .rst, .host_pin_b, .host_pin_d, .host_pin_c_q, .host_pin_c_oe_n_q,
  .host_kind_q, .host_kind_valid_q, .reg_wr_q, .reg_rd_q, .fifo_push_q, .reg_addr_q);
`default_nettype wire

// *** tb/hssp_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
module hssp_host_model (
  output logic sck,
  output logic mosi,
  output logic nss_n,
  input wire logic miso
);
  initial begin
    sck = 1'b0;
    mosi = 1'b0;
    nss_n = 1'b1;
  end
  task automatic xfer(input logic [7:0] tx, input int nb, output logic [7:0] rx);
    for (int i = 7; i > 7 - nb; i--) begin
      mosi = tx[i];
      #80 sck = 1'b1;
      rx[i] = miso;
      #80 sck = 1'b0;
    end
  endtask
  // select framing
  // Delays are multiples of the clock period, so pins move on falling clock edges
  task automatic sel(input logic on);
    #96 nss_n = ~on;
    if (!on) begin
      // Deselected data line must not keep its last value
      mosi = ~mosi;
    end
  endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin comparisons++; if ((g) !== (e)) begin errors++; \
  $display("unexpected %s exp %h got %h", n, e, g); end end
module tb;
  import hssp_pkg::*;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic host_kind_strap_lo = 1'b0;
  logic host_kind_strap_hi = 1'b1;
  wire host_pin_a, host_pin_b, host_pin_d;
  logic host_pin_c_q, host_pin_c_oe_n_q, host_kind_valid_q, reg_wr_q, reg_rd_q, fifo_push_q;
  hssp_host_kind_t host_kind_q;
  logic [6:0] reg_addr_q;
  logic [7:0] reg_wdata_q, reg_rdata;
  logic [7:0] rxq[$];
  logic [15:0] log_q[$];
  int errors = 0;
  int comparisons = 0;
  int cycles = 0;
  wire miso_w = host_pin_c_oe_n_q ? 1'bz : host_pin_c_q;
  always #4 clk = ~clk;
  // Register file seen by the port
  assign reg_rdata = {reg_addr_q, 1'b0} ^ 8'ha5;
  hssp_top i_hssp_top (.clk, .rst, .host_kind_strap_lo, .host_kind_strap_hi, .host_pin_a, .host_pin_b,
    .host_pin_d, .host_pin_c_q, .host_pin_c_oe_n_q, .host_kind_q, .host_kind_valid_q, .reg_wr_q, .reg_rd_q,
    .fifo_push_q, .reg_addr_q, .reg_wdata_q, .reg_rdata);
  hssp_host_model i_hssp_host_model (.sck(host_pin_b), .mosi(host_pin_a), .nss_n(host_pin_d), .miso(miso_w));
  always @(posedge clk) begin
    cycles++;
    if (reg_wr_q | fifo_push_q)
      log_q.push_back({fifo_push_q, reg_addr_q, reg_wdata_q});
    if (cycles == 30000) begin
      errors++;
      stop_test();
    end
  end
  task automatic stop_test();
    $display("comparisons %0d errors %0d", comparisons, errors);
    if (errors == 0 && comparisons > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  task automatic do_reset(input logic lo, input logic hi);
    @(negedge clk);
    rst = 1'b1;
    host_kind_strap_lo = lo;
    host_kind_strap_hi = hi;
    repeat (20) @(negedge clk);
    rst = 1'b0;
    repeat (HSSP_COLD_RESET_CYC + 8) @(negedge clk);
  endtask
  task automatic frame(input logic [7:0] b[$]);
    logic [7:0] rx;
    rxq = {};
    log_q = {};
    i_hssp_host_model.sel(1'b1);
    foreach (b[k]) begin
      i_hssp_host_model.xfer(b[k], 8, rx);
      rxq.push_back(rx);
    end
    i_hssp_host_model.sel(1'b0);
    repeat (20) @(negedge clk);
  endtask
  task automatic t_straps();
    hssp_host_kind_t ek[4] = '{HSSP_HOST_UART, HSSP_HOST_I2C, HSSP_HOST_SPI, HSSP_HOST_I2CL};
    for (int i = 0; i < 4; i++) begin
      do_reset(i[0], i[1]);
      `CHK("host kind", ek[i], host_kind_q)
      `CHK("kind valid", 1'b1, host_kind_valid_q)
    end
    // Bytes are ignored outside spi mode
    frame('{8'h20, 8'h55});
    `CHK("ignored frame", 0, log_q.size())
  endtask
  task automatic t_write();
    logic [7:0] d[3] = '{8'h3c, 8'hc3, 8'h81};
    frame('{8'h20, d[0], d[1], d[2]});
    `CHK("write count", 3, log_q.size())
    for (int k = 0; k < 3; k++) begin
      `CHK("write entry", {1'b0, 7'h10 + 7'(k), d[k]}, log_q[k])
      `CHK("write miso", 8'h00, rxq[k])
    end
  endtask
  task automatic t_fifo();
    frame('{8'h0a, 8'h11, 8'h22});
    `CHK("push count", 2, log_q.size())
    `CHK("push one", {1'b1, 7'h05, 8'h11}, log_q[0])
    `CHK("push two", {1'b1, 7'h05, 8'h22}, log_q[1])
  endtask
  task automatic t_read();
    frame('{8'h07, 8'h09, 8'h00});
    `CHK("read first", 8'h00, rxq[0])
    `CHK("read data 03", 8'h06 ^ 8'ha5, rxq[1])
    `CHK("read data 04", 8'h08 ^ 8'ha5, rxq[2])
    `CHK("read writes", 0, log_q.size())
  endtask
  task automatic t_abort();
    logic [7:0] rx;
    i_hssp_host_model.sel(1'b1);
    i_hssp_host_model.xfer(8'h20, 4, rx);
    i_hssp_host_model.sel(1'b0);
    frame('{8'h60, 8'h5a});
    `CHK("abort count", 1, log_q.size())
    `CHK("abort entry", {1'b0, 7'h30, 8'h5a}, log_q[0])
  endtask
  initial begin
    t_straps();
    do_reset(1'b0, 1'b1);
    t_write();
    t_fifo();
    t_read();
    t_abort();
    stop_test();
  end
endmodule
`default_nettype wire
